// [core/link_control_regs.v]
/*
 * Link control bits, node report buffer base and node report count
 * registers with a sticky interrupt status, behind a plain register port.
 * Assumes one clock, synchronous link event pulses one cycle long, and a
 * DMA engine that reports reception start, quadlets, errors and the end.
 */
//
// Behaviour
// RULE1: Link power bit 19 gates every link-to-PHY communication.
// RULE2: Control bit 18 enables or disables buffered write handling.
// RULE3: Software changes bit 18 only while link active is 0.
// RULE4: Hardware reset and local reinit both clear link active.
// RULE5: Software sets link active when ready, then forces a bus reset.
// RULE6: With link active 0 no packet is received, processed or sent.
// RULE7: Local reinit resets link state, flushes FIFOs, restores reset values.
// RULE8: Local reinit bit reads 1 while in progress, then clears itself.
// RULE9: Control bits 21-20 and 15-0 read as zero.
// RULE10: Node packets go to the buffer at the base pointer.
// RULE11: Base pointer keeps bits 31-11 only; lower bits read zero.
// RULE12: Fault bit 31 sets on an error in the latest reception.
// RULE13: Fault raised by reception hardware error or host write failure.
// RULE14: Fault clears after a later reception ends without error.
// RULE15: Epoch bits 23-16 count bus resets and wrap after 255.
// RULE16: Quadlet count bits 10-2 counts quadlets written, header included.
// RULE17: Quadlet count is zeroed when a new reception starts.
// RULE18: Count bits 30-24, 15-11 and 1-0 read as zero.
// RULE19: Set address sets ones, clear address clears ones, zeros ignored.
`timescale 1ns/1ps
`include "link_regs_map.vh"

module link_control_regs #(
    parameter REINIT_CYCLES = `REINIT_CYCLES_DEF
) (
    // Clock and reset
    input  wire        mclk,
    input  wire        rst_b,
    // Register port
    input  wire [7:0]  addr,
    input  wire [31:0] wdata,
    input  wire        wr_stb,
    input  wire        rd_stb,
    output reg  [31:0] rdata,
    // Link events
    input  wire        bus_reset_seen,
    input  wire        report_start,
    input  wire        report_quadlet,
    input  wire        report_done,
    input  wire        report_hw_error,
    input  wire        host_write_fail,
    // Link control outputs
    output reg         phy_comm_allow,
    output reg         buffered_write_on,
    output reg         link_attached,
    output reg         fifo_flush,
    output reg  [31:0] report_buf_base,
    // Interrupt
    output reg         irq
);

    reg                     power_reg;
    reg                     power_next;
    reg                     bwa_reg;
    reg                     bwa_next;
    reg                     active_reg;
    reg                     active_next;
    reg [`BUF_BASE_W-1:0]   base_reg;
    reg [`BUF_BASE_W-1:0]   base_next;
    reg                     fault_reg;
    reg                     fault_next;
    reg [`EPOCH_W-1:0]      epoch_reg;
    reg [`EPOCH_W-1:0]      epoch_next;
    reg [`QUAD_W-1:0]       quad_reg;
    reg [`QUAD_W-1:0]       quad_next;
    reg                     rx_busy_reg;
    reg                     rx_busy_next;
    reg                     rx_err_reg;
    reg                     rx_err_next;
    reg [`IRQ_W-1:0]        stat_reg;
    reg [`IRQ_W-1:0]        stat_next;
    reg [`IRQ_W-1:0]        mask_reg;
    reg [`IRQ_W-1:0]        mask_next;
    reg [`IRQ_W-1:0]        stat_set;
    reg [31:0]              rd_word;

    wire                    reinit_busy;
    wire                    reinit_done;
    wire                    wr_set;
    wire                    wr_clr;
    wire                    reinit_start;
    wire                    phy_ok;
    wire                    rx_ok;

    assign wr_set = wr_stb && (addr == `OFS_CTRL_SET);
    assign wr_clr = wr_stb && (addr == `OFS_CTRL_CLR);

    // A second set while one is running is ignored; it would only extend it.
    assign reinit_start = wr_set && wdata[`BIT_LOCAL_REINIT]
                          && !reinit_busy; // RULE7

    // Bus reset detection needs the PHY path to be open.
    assign phy_ok = power_reg && !reinit_busy; // RULE1

    // Packet reception needs both the PHY path and an attached link.
    assign rx_ok = phy_ok && active_reg; // RULE6

    reinit_seq #(
        .CYCLES (REINIT_CYCLES)
    ) u_reinit (
        .mclk   (mclk),
        .rst_b  (rst_b),
        .start  (reinit_start),
        .busy   (reinit_busy),
        .done   (reinit_done)
    );

    always @* begin
        power_next   = power_reg;
        bwa_next     = bwa_reg;
        active_next  = active_reg;
        base_next    = base_reg;
        fault_next   = fault_reg;
        epoch_next   = epoch_reg;
        quad_next    = quad_reg;
        rx_busy_next = rx_busy_reg;
        rx_err_next  = rx_err_reg;
        mask_next    = mask_reg;
        stat_set     = `RST_IRQ;

        if (reinit_busy || reinit_start) begin
            // Link state sits at its reset values for the whole run.
            power_next   = `RST_CTRL_BIT; // RULE7
            bwa_next     = `RST_CTRL_BIT; // RULE7
            active_next  = `RST_CTRL_BIT; // RULE4
            base_next    = `RST_BUF_BASE; // RULE7
            fault_next   = 1'b0; // RULE7
            epoch_next   = `RST_EPOCH; // RULE7
            quad_next    = `RST_QUAD; // RULE7
            rx_busy_next = 1'b0; // RULE7
            rx_err_next  = 1'b0; // RULE7
        end else begin
            if (wr_set) begin
                power_next  = power_reg
                              | wdata[`BIT_LINK_POWER_ON]; // RULE19
                bwa_next    = bwa_reg
                              | wdata[`BIT_BUF_WRITE_ALLOW]; // RULE2
                active_next = active_reg
                              | wdata[`BIT_LINK_ACTIVE]; // RULE19
            end
            if (wr_clr) begin
                power_next  = power_reg
                              & ~wdata[`BIT_LINK_POWER_ON]; // RULE19
                bwa_next    = bwa_reg
                              & ~wdata[`BIT_BUF_WRITE_ALLOW]; // RULE2
                active_next = active_reg
                              & ~wdata[`BIT_LINK_ACTIVE]; // RULE19
            end
            if (wr_stb && (addr == `OFS_BUF_BASE)) begin
                base_next = wdata[31:`BUF_BASE_LSB]; // RULE11
            end

            if (phy_ok && bus_reset_seen) begin
                epoch_next = epoch_reg + 8'h01; // RULE15
                stat_set[`IRQ_BUS_RESET] = 1'b1;
            end

            if (rx_ok) begin
                if (report_start) begin
                    rx_busy_next = 1'b1;
                    rx_err_next  = 1'b0;
                    quad_next    = `RST_QUAD; // RULE17
                end
                if (report_quadlet && (rx_busy_next)) begin
                    // Saturate rather than wrap so a runaway never reads small.
                    if (quad_next != {`QUAD_W{1'b1}}) begin
                        quad_next = quad_next + 9'h001; // RULE16
                    end
                end
                if ((report_hw_error || host_write_fail)
                    && rx_busy_next) begin
                    rx_err_next = 1'b1; // RULE13
                    if (!fault_reg) begin
                        stat_set[`IRQ_REPORT_FAULT] = 1'b1;
                    end
                    fault_next = 1'b1; // RULE12
                end
                if (report_done && rx_busy_next) begin
                    rx_busy_next = 1'b0;
                    stat_set[`IRQ_REPORT_DONE] = 1'b1;
                    if (!rx_err_next) begin
                        fault_next = 1'b0; // RULE14
                    end
                end
            end else if (!active_reg) begin
                // A detach drops any reception in flight.
                rx_busy_next = 1'b0; // RULE6
            end
        end

        if (reinit_done) begin
            stat_set[`IRQ_REINIT_DONE] = 1'b1;
        end

        if (wr_stb && (addr == `OFS_IRQ_MASK)) begin
            mask_next = wdata[`IRQ_W-1:0];
        end

        // A read clears the status, but an event in the same cycle wins.
        stat_next = stat_reg;
        if (rd_stb && (addr == `OFS_IRQ_STATUS)) begin
            stat_next = `RST_IRQ;
        end
        stat_next = stat_next | stat_set;
    end

    always @* begin
        rd_word = `RST_WORD;
        case (addr)
            `OFS_CTRL_SET, `OFS_CTRL_CLR: begin
                rd_word[`BIT_LINK_POWER_ON]   = power_reg;
                rd_word[`BIT_BUF_WRITE_ALLOW] = bwa_reg;
                rd_word[`BIT_LINK_ACTIVE]     = active_reg;
                rd_word[`BIT_LOCAL_REINIT]    = reinit_busy; // RULE8
                // All other control bits stay at zero here. RULE9
            end
            `OFS_BUF_BASE: begin
                rd_word[31:`BUF_BASE_LSB] = base_reg; // RULE11
            end
            `OFS_REPORT_COUNT: begin
                rd_word[`BIT_REPORT_FAULT] = fault_reg; // RULE12
                rd_word[`EPOCH_LSB+`EPOCH_W-1:`EPOCH_LSB] = epoch_reg;
                rd_word[`QUAD_LSB+`QUAD_W-1:`QUAD_LSB] = quad_reg;
                // Gaps between the fields read as zero. RULE18
            end
            `OFS_IRQ_STATUS: begin
                rd_word[`IRQ_W-1:0] = stat_reg;
            end
            `OFS_IRQ_MASK: begin
                rd_word[`IRQ_W-1:0] = mask_reg;
            end
            default: begin
                rd_word = `RST_WORD;
            end
        endcase
    end

    always @(posedge mclk) begin
        if (!rst_b) begin
            power_reg   <= `RST_CTRL_BIT;
            bwa_reg     <= `RST_CTRL_BIT;
            active_reg  <= `RST_CTRL_BIT; // RULE4
            base_reg    <= `RST_BUF_BASE;
            fault_reg   <= 1'b0;
            epoch_reg   <= `RST_EPOCH;
            quad_reg    <= `RST_QUAD;
            rx_busy_reg <= 1'b0;
            rx_err_reg  <= 1'b0;
            stat_reg    <= `RST_IRQ;
            mask_reg    <= `RST_IRQ;
        end else begin
            power_reg   <= power_next;
            bwa_reg     <= bwa_next;
            active_reg  <= active_next;
            base_reg    <= base_next;
            fault_reg   <= fault_next;
            epoch_reg   <= epoch_next;
            quad_reg    <= quad_next;
            rx_busy_reg <= rx_busy_next;
            rx_err_reg  <= rx_err_next;
            stat_reg    <= stat_next;
            mask_reg    <= mask_next;
        end
    end

    // Outputs except rdata and fifo_flush are separate flops loaded with the same next values.
    always @(posedge mclk) begin
        if (!rst_b) begin
            rdata             <= `RST_WORD;
            phy_comm_allow    <= 1'b0;
            buffered_write_on <= 1'b0;
            link_attached     <= 1'b0;
            fifo_flush        <= 1'b0;
            report_buf_base   <= `RST_WORD;
            irq               <= 1'b0;
        end else begin
            rdata             <= rd_stb ? rd_word : `RST_WORD;
            phy_comm_allow    <= power_next && !reinit_start; // RULE1
            buffered_write_on <= bwa_next && !reinit_start; // RULE2
            link_attached     <= power_next && active_next
                                 && !reinit_start; // RULE6
            fifo_flush        <= reinit_start
                                 || (reinit_busy && !reinit_done); // RULE7
            report_buf_base   <= {base_next,
                                  {`BUF_BASE_LSB{1'b0}}}; // RULE10
            irq               <= |(stat_next & mask_next);
        end
    end

endmodule // link_control_regs

// [core/link_regs_map.vh]
/*
 * Register offsets, field positions, reset values and timing counts
 * for the link control and node report register bank.
 * Assumes byte addresses on an 8-bit register port, one word each.
 */
`ifndef LINK_REGS_MAP_VH
`define LINK_REGS_MAP_VH

// Register byte offsets.
`define OFS_CTRL_SET        8'h50
`define OFS_CTRL_CLR        8'h54
`define OFS_BUF_BASE        8'h64
`define OFS_REPORT_COUNT    8'h68
`define OFS_IRQ_STATUS      8'h80
`define OFS_IRQ_MASK        8'h84

// Host control field positions.
`define BIT_LINK_POWER_ON   19
`define BIT_BUF_WRITE_ALLOW 18
`define BIT_LINK_ACTIVE     17
`define BIT_LOCAL_REINIT    16

// Buffer base field.
`define BUF_BASE_LSB        11
`define BUF_BASE_W          21

// Node report count fields.
`define BIT_REPORT_FAULT    31
`define EPOCH_LSB           16
`define EPOCH_W             8
`define QUAD_LSB            2
`define QUAD_W              9

// Interrupt status and mask bit positions.
`define IRQ_BUS_RESET       0
`define IRQ_REPORT_DONE     1
`define IRQ_REPORT_FAULT    2
`define IRQ_REINIT_DONE     3
`define IRQ_W               4

// Reset values.
`define RST_CTRL_BIT        1'b0
`define RST_BUF_BASE        21'h00_0000
`define RST_EPOCH           8'h00
`define RST_QUAD            9'h000
`define RST_IRQ             4'h0
`define RST_WORD            32'h0000_0000

// Cycles that a local reinitialisation stays in progress.
`define REINIT_CYCLES_DEF   16

`endif

// [core/reinit_seq.v]
/*
 * Sequencer that holds the local reinitialisation in progress for a
 * fixed number of cycles and then reports completion.
 * Assumes a single clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps

module reinit_seq #(
    parameter CYCLES = 16
) (
    // Clock and reset
    input  wire       mclk,
    input  wire       rst_b,
    // Control
    input  wire       start,
    // Status
    output reg        busy,
    output reg        done
);

    localparam ST_IDLE = 1'b0;
    localparam ST_RUN  = 1'b1;
    localparam [15:0] LAST = CYCLES - 1;

    reg        state_reg;
    reg [15:0] cnt_reg;

    always @(posedge mclk) begin
        if (!rst_b) begin
            state_reg <= ST_IDLE;
            cnt_reg   <= 16'h0000;
            busy      <= 1'b0;
            done      <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (start) begin
                        state_reg <= ST_RUN;
                        cnt_reg   <= 16'h0000;
                        busy      <= 1'b1;
                        done      <= (LAST == 16'h0000);
                    end
                end
                ST_RUN: begin
                    if (cnt_reg == LAST) begin
                        // Busy drops by itself once the count runs out.
                        state_reg <= ST_IDLE;
                        busy      <= 1'b0;
                    end else begin
                        // Done flags the last busy cycle, so users see
                        // the end at the same edge at which busy falls.
                        cnt_reg <= cnt_reg + 16'h0001;
                        done    <= (cnt_reg + 16'h0001 == LAST);
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                    busy      <= 1'b0;
                end
            endcase
        end
    end

endmodule // reinit_seq

// [verification/link_regs_assertions.sv]
/* Checker on the ports of link_control_regs.
   Assumes one clock, a synchronous active-low reset and the bind below. */
`timescale 1ns/1ps

module link_regs_assertions #(
    parameter REINIT_CYCLES = 16
) (
    // Clock, reset and register port
    input wire        mclk,
    input wire        rst_b,
    input wire [7:0]  addr,
    input wire [31:0] wdata,
    input wire        wr_stb,
    input wire        rd_stb,
    input wire [31:0] rdata,
    // Link control outputs
    input wire        phy_comm_allow,
    input wire        buffered_write_on,
    input wire        link_attached,
    input wire        fifo_flush,
    input wire [31:0] report_buf_base,
    input wire        irq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);

    reg  [7:0] flush_cnt;
    // Set and clear writes during a reinit are refused, so they are left out here.
    wire       set_w = wr_stb && addr == 8'h50 && !fifo_flush;
    wire       clr_w = wr_stb && addr == 8'h54 && !fifo_flush;

    always @(posedge mclk) begin
        if (!rst_b || !fifo_flush)
            flush_cnt <= 8'h00;
        else
            flush_cnt <= flush_cnt + 8'h01;
    end

    chk_power_gate: assert property (link_attached |-> phy_comm_allow)
        else $error("Link attached with power off.");
    chk_bwa_set: assert property (set_w && wdata[18] && !wdata[16] |=>
        buffered_write_on) else $error("Buffered write not set.");
    chk_bwa_clear: assert property (clr_w && wdata[18] |=>
        !buffered_write_on) else $error("Buffered write not cleared.");
    chk_active_clear: assert property (clr_w && wdata[17] |=>
        !link_attached) else $error("Link still attached.");
    chk_reinit_start: assert property (set_w && wdata[16] |=>
        fifo_flush && !link_attached && !phy_comm_allow
        && report_buf_base == 32'h0000_0000)
        else $error("Reinit did not clear link state.");
    chk_reinit_len: assert property ($fell(fifo_flush) |->
        flush_cnt == REINIT_CYCLES) else $error("Reinit length wrong.");
    chk_ctrl_read: assert property (rd_stb && (addr == 8'h50 ||
        addr == 8'h54) |=> rdata[21:20] == 2'b00 && rdata[15:0] == 16'h0000
        && rdata[19] == $past(phy_comm_allow)
        && rdata[16] == $past(fifo_flush))
        else $error("Control read wrong.");
    chk_base_read: assert property (rd_stb && addr == 8'h64 |=>
        rdata == $past(report_buf_base) && rdata[10:0] == 11'h000)
        else $error("Base read wrong.");
    chk_count_zero: assert property (rd_stb && addr == 8'h68 |=>
        rdata[30:24] == 7'h00 && rdata[15:11] == 5'h00 && rdata[1:0] == 2'h0)
        else $error("Count reserved bits set.");

    cover property ($fell(fifo_flush));
    cover property (rd_stb && addr == 8'h68 ##1 rdata[31]);
    cover property ($rose(irq));
endmodule // link_regs_assertions

bind link_control_regs link_regs_assertions #(
    .REINIT_CYCLES(REINIT_CYCLES)
) u_chk (
    .mclk(mclk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .phy_comm_allow(phy_comm_allow), .buffered_write_on(buffered_write_on),
    .link_attached(link_attached), .fifo_flush(fifo_flush),
    .report_buf_base(report_buf_base), .irq(irq)
);

// [verification/link_far_end.sv]
/* Far side of the link: bus reset detection and the DMA engine that
   stores node packets and reports each reception.
   Assumes the bench hands it one event word per clock cycle. */
`timescale 1ns/1ps

module link_far_end (
    // Link events
    output reg bus_reset_seen,
    output reg report_start,
    output reg report_quadlet,
    output reg report_done,
    output reg report_hw_error,
    output reg host_write_fail
);
    initial begin
        put(6'h00);
    end

    // Word order: bus reset, start, quadlet, done, hw error, write fail.
    task put(input [5:0] v);
        {bus_reset_seen, report_start, report_quadlet, report_done,
         report_hw_error, host_write_fail} <= v;
    endtask

    // Cycle i of a reception of nq quadlets; err 1 faults the first
    // quadlet in reception, err 2 fails the host write of the last one.
    function [5:0] frame_ev(input integer i, input integer nq,
                            input integer err);
        if (i == 0)
            frame_ev = 6'h10;
        else if (i > nq)
            frame_ev = 6'h04;
        else
            frame_ev = {3'b001, 1'b0, err == 1 && i == 1,
                        err == 2 && i == nq};
    endfunction
endmodule // link_far_end

// [verification/tb_top.sv]
/* Self-checking bench for link_control_regs with the far-side model.
   Assumes read data in the cycle after the read strobe only. */
`timescale 1ns/1ps

module tb_top;
    localparam REINIT = 4;
    reg         mclk = 1'b0;
    reg         rst_b = 1'b0;
    reg  [7:0]  addr = 8'h00;
    reg  [31:0] wdata = 32'h0000_0000;
    reg         wr_stb = 1'b0;
    reg         rd_stb = 1'b0;
    reg         rd_pend = 1'b0;
    wire [31:0] rdata;
    wire [31:0] report_buf_base;
    wire        bus_reset_seen, report_start, report_quadlet, report_done;
    wire        report_hw_error, host_write_fail, irq;
    wire        phy_comm_allow, buffered_write_on, link_attached, fifo_flush;
    integer     err_count = 0;
    integer     samples_checked = 0;
    integer     cycles = 0;
    integer     seed = 32'h32cf;
    integer     i;
    integer     k;
    reg  [31:0] exp_q[$];
    reg  [31:0] r;
    reg  [55:0] alist = 56'h5054_6468_8084_40;

    link_control_regs #(.REINIT_CYCLES(REINIT)) dut (
        .mclk(mclk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
        .bus_reset_seen(bus_reset_seen), .report_start(report_start),
        .report_quadlet(report_quadlet), .report_done(report_done),
        .report_hw_error(report_hw_error), .host_write_fail(host_write_fail),
        .phy_comm_allow(phy_comm_allow), .buffered_write_on(buffered_write_on),
        .link_attached(link_attached), .fifo_flush(fifo_flush),
        .report_buf_base(report_buf_base), .irq(irq));

    link_far_end u_far (
        .bus_reset_seen(bus_reset_seen), .report_start(report_start),
        .report_quadlet(report_quadlet), .report_done(report_done),
        .report_hw_error(report_hw_error), .host_write_fail(host_write_fail));

    initial begin
        forever #50 mclk = ~mclk;
    end

    task stop_test;
        begin
            if (err_count == 0 && samples_checked > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask

    task cmp(input [31:0] act, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (act !== exp) begin
                err_count = err_count + 1;
                $display("Error at %0t: got %h expected %h", $time, act, exp);
            end
        end
    endtask

    // Values read right after the edge are those of the cycle just ended.
    task step(input w, input rs, input [7:0] a, input [31:0] d,
              input [5:0] ev);
        begin
            wr_stb <= w;
            rd_stb <= rs;
            addr <= a;
            wdata <= d;
            u_far.put(ev);
            @(posedge mclk);
        end
    endtask

    task wr(input [7:0] a, input [31:0] d);
        step(1'b1, 1'b0, a, d, 6'h00);
    endtask

    task rd(input [7:0] a, input [31:0] e);
        begin
            exp_q.push_back(e);
            step(1'b0, 1'b1, a, 32'h0000_0000, 6'h00);
        end
    endtask

    task idle(input integer n);
        repeat (n) step(1'b0, 1'b0, 8'h00, 32'h0000_0000, 6'h00);
    endtask

    task frame(input integer nq, input integer err);
        integer j;
        begin
            for (j = 0; j <= nq + 1; j = j + 1)
                step(1'b0, 1'b0, 8'h00, 32'h0000_0000,
                     u_far.frame_ev(j, nq, err));
            idle(1);
        end
    endtask

    // Read data are compared one cycle after the strobe, oldest note first.
    always @(posedge mclk) begin
        if (rd_pend)
            cmp(rdata, exp_q.pop_front());
        rd_pend <= rd_stb;
        cycles = cycles + 1;
        if (cycles == 5000) begin
            err_count = err_count + 1;
            stop_test;
        end
    end

    initial begin
        repeat (4) @(posedge mclk);
        rst_b <= 1'b1;
        idle(1);
        for (i = 0; i < 7; i = i + 1)
            rd(alist[8 * i +: 8], 32'h0000_0000);
        wr(8'h84, 32'h0000_0005);
        for (k = 0; k < 4; k = k + 1) begin
            r = $random(seed);
            wr(8'h64, r);
            rd(8'h64, r & 32'hFFFF_F800);
            cmp(report_buf_base, r & 32'hFFFF_F800);
        end
        wr(8'h50, 32'h000C_0000 | ($random(seed) & 32'h0030_FFFF));
        rd(8'h50, 32'h000C_0000);
        wr(8'h50, 32'h0002_0000);
        rd(8'h54, 32'h000E_0000);
        cmp({phy_comm_allow, buffered_write_on, link_attached}, 3'h7);
        repeat (255) step(1'b0, 1'b0, 8'h00, 32'h0000_0000, 6'h20);
        idle(1);
        rd(8'h68, 32'h00FF_0000);
        repeat (2) step(1'b0, 1'b0, 8'h00, 32'h0000_0000, 6'h20);
        idle(2);
        rd(8'h68, 32'h0001_0000);
        cmp(irq, 1'b1);
        rd(8'h80, 32'h0000_0001);
        idle(2);
        cmp(irq, 1'b0);
        frame(3, 0);
        rd(8'h68, 32'h0001_000C);
        frame(2, 1);
        rd(8'h68, 32'h8001_0008);
        frame(1, 0);
        rd(8'h68, 32'h0001_0004);
        frame(2, 2);
        rd(8'h68, 32'h8001_0008);
        cmp(irq, 1'b1);
        rd(8'h80, 32'h0000_0006);
        wr(8'h54, 32'h0002_0000);
        frame(3, 0);
        rd(8'h68, 32'h8001_0008);
        cmp({phy_comm_allow, link_attached}, 2'h2);
        wr(8'h54, 32'h000C_0000);
        step(1'b0, 1'b0, 8'h00, 32'h0000_0000, 6'h20);
        idle(1);
        rd(8'h68, 32'h8001_0008);
        cmp({phy_comm_allow, buffered_write_on}, 2'h0);
        wr(8'h50, 32'h0001_0000);
        wr(8'h64, 32'hFFFF_F800);
        rd(8'h50, 32'h0001_0000);
        for (k = 0; k < 20 && fifo_flush !== 1'b0; k = k + 1)
            idle(1);
        rd(8'h50, 32'h0000_0000);
        rd(8'h64, 32'h0000_0000);
        rd(8'h68, 32'h0000_0000);
        rd(8'h80, 32'h0000_0008);
        idle(3);
        stop_test;
    end
endmodule // tb_top
